// [src/synced_twelve_phase_pwm.sv]
// Added by the designer: register access over Avalon-MM and the register addresses.
`default_nettype none
module synced_twelve_phase_pwm
	import pwm_sync_pkg::*;
(
	// Clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Avalon-MM slave
	input  wire logic [7:0]                    address,
	input  wire logic                          read,
	input  wire logic                          write,
	input  wire logic [31:0]                   writedata,
	input  wire logic [3:0]                    byteenable,
	output logic      [31:0]                   readdata,
	output logic                               waitrequest,
	// Pins
	output logic      [pwm_sync_pkg::PHASES-1:0] pwm_out,
	output logic                               period_channel_output_a
);
	import pwm_sync_pkg::*;

	typedef struct packed {
		logic [PRE_W-1:0]   pre;
		logic [CH_NUM-1:0]  run;
		logic [CNT_W-1:0]   per_cnt;
		logic               per_pin;
		logic [CNT_W-1:0]   general_register_a;
		logic [PHASES*CNT_W-1:0] duty;
		logic [31:0]        rdata;
		logic               ack;
	} top_state_t;
	top_state_t st;
	top_state_t next_st;

	logic            tick;
	logic            per_match;
	logic            sync_clear;
	logic [CH_NUM-1:0] start_pulse;
	logic            req;
	logic [CNT_W-1:0] cnt0;
	logic [CNT_W-1:0] cnt1;
	logic [CNT_W-1:0] cnt2;
	logic [CNT_W-1:0] cnt9;
	logic [3:0]      duty_idx;
	logic            duty_hit;
	logic [7:0]      duty_off;
	logic            wr_take;

	assign tick = (st.pre == PRE_W'(PRESCALE - 1));
	assign per_match = st.run[BIT_PER] && tick
		&& (st.per_cnt == st.general_register_a);
	assign sync_clear = per_match;
	assign req = (read || write) && !st.ack;
	assign waitrequest = !st.ack;
	assign readdata = st.rdata;
	// Duty index counts words from the base of the duty block
	assign duty_off = address - OFF_DUTY_BASE;
	assign duty_idx = duty_off[5:2];
	// A write lands only at the edge that sees waitrequest low
	assign wr_take = write && st.ack;
	assign duty_hit = (address >= OFF_DUTY_BASE)
		&& (address < OFF_DUTY_BASE + 8'(PHASES * 4));

	// Start bits only fire on the accepting write
	always_comb begin
		start_pulse = '0;
		if (wr_take && address == OFF_SYNC_START && byteenable[0]) begin
			start_pulse = writedata[CH_NUM-1:0] & ~st.run;
		end
	end

	always_comb begin
		next_st = st;
		next_st.ack = req;
		next_st.pre = tick ? '0 : st.pre + 1'b1;
		// Period channel, normal mode only
		if (start_pulse[BIT_PER]) begin
			next_st.per_cnt = RST_CNT;
			next_st.per_pin = 1'b0;
		end else if (st.run[BIT_PER] && tick) begin
			if (per_match) begin
				next_st.per_cnt = RST_CNT;
				next_st.per_pin = ~st.per_pin;
			end else begin
				next_st.per_cnt = st.per_cnt + 1'b1;
			end
		end
		next_st.run = st.run | start_pulse;
		if (wr_take) begin
			if (address == OFF_STOP && byteenable[0]) begin
				next_st.run = st.run & ~writedata[CH_NUM-1:0];
			end
			if (address == OFF_PERIOD_A) begin
				for (int b = 0; b < 2; b++) begin
					if (byteenable[b]) begin
						next_st.general_register_a[b*8 +: 8] =
							writedata[b*8 +: 8];
					end
				end
			end
			if (duty_hit) begin
				for (int b = 0; b < 2; b++) begin
					if (byteenable[b]) begin
						next_st.duty[duty_idx*CNT_W + b*8 +: 8] =
							writedata[b*8 +: 8];
					end
				end
			end
		end
		next_st.rdata = 32'h0000_0000;
		if (req && read) begin
			if (address == OFF_SYNC_START || address == OFF_STATUS) begin
				next_st.rdata = 32'(st.run);
			end else if (address == OFF_PERIOD_A) begin
				next_st.rdata = 32'(st.general_register_a);
			end else if (address == OFF_PERIOD_CNT) begin
				next_st.rdata = 32'(st.per_cnt);
			end else if (duty_hit) begin
				next_st.rdata = 32'(st.duty[duty_idx*CNT_W +: CNT_W]);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st.pre <= '0;
			st.run <= '0;
			st.per_cnt <= RST_CNT;
			st.per_pin <= 1'b0;
			st.general_register_a <= RST_PERIOD;
			st.duty <= {PHASES{RST_DUTY}};
			st.rdata <= 32'h0000_0000;
			st.ack <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign period_channel_output_a = st.per_pin;

	// Duty A-D on ch0, A-B on ch1/ch2, A-D on ch9
	pwm_channel #(.CNT_W(CNT_W), .OUTS(4)) pwm_channel_zero (
		.clk             (clk),
		.rst_n           (rst_n),
		.tick            (tick),
		.run             (st.run[BIT_CH0]),
		.start           (start_pulse[BIT_CH0]),
		.sync_clear      (sync_clear),
		.duty            (st.duty[4*CNT_W-1:0]),
		.channel_counter (cnt0),
		.pwm_out         (pwm_out[3:0])
	);
	pwm_channel #(.CNT_W(CNT_W), .OUTS(2)) pwm_channel_one (
		.clk             (clk),
		.rst_n           (rst_n),
		.tick            (tick),
		.run             (st.run[BIT_CH1]),
		.start           (start_pulse[BIT_CH1]),
		.sync_clear      (sync_clear),
		.duty            (st.duty[6*CNT_W-1:4*CNT_W]),
		.channel_counter (cnt1),
		.pwm_out         (pwm_out[5:4])
	);
	pwm_channel #(.CNT_W(CNT_W), .OUTS(2)) pwm_channel_two (
		.clk             (clk),
		.rst_n           (rst_n),
		.tick            (tick),
		.run             (st.run[BIT_CH2]),
		.start           (start_pulse[BIT_CH2]),
		.sync_clear      (sync_clear),
		.duty            (st.duty[8*CNT_W-1:6*CNT_W]),
		.channel_counter (cnt2),
		.pwm_out         (pwm_out[7:6])
	);
	pwm_channel #(.CNT_W(CNT_W), .OUTS(4)) pwm_channel_nine (
		.clk             (clk),
		.rst_n           (rst_n),
		.tick            (tick),
		.run             (st.run[BIT_CH9]),
		.start           (start_pulse[BIT_CH9]),
		.sync_clear      (sync_clear),
		.duty            (st.duty[12*CNT_W-1:8*CNT_W]),
		.channel_counter (cnt9),
		.pwm_out         (pwm_out[11:8])
	);

	// Count clock and period channel
	tick_period_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
		else $error("count tick not every fourth cycle");
	pre_step_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		!tick |=> st.pre == $past(st.pre) + 1'b1)
		else $error("prescaler did not advance");
	per_idle_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		!tick && !start_pulse[BIT_PER] |=> $stable(st.per_cnt))
		else $error("period counter moved between ticks");
	per_step_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		st.run[BIT_PER] && tick && !per_match && !start_pulse[BIT_PER]
		|=> st.per_cnt == $past(st.per_cnt) + 1'b1)
		else $error("period counter did not step by one");
	per_stop_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		!st.run[BIT_PER] && !start_pulse[BIT_PER]
		|=> $stable(st.per_cnt))
		else $error("stopped period counter moved");
	period_wrap_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		per_match && !start_pulse[BIT_PER] |=> st.per_cnt == '0)
		else $error("period counter not cleared on match");
	toggle_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		per_match && !start_pulse[BIT_PER] |=>
		period_channel_output_a != $past(period_channel_output_a))
		else $error("period output did not toggle");
	pin_hold_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		!per_match && !start_pulse[BIT_PER]
		|=> $stable(period_channel_output_a))
		else $error("period output moved without match");
	per_start_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		start_pulse[BIT_PER]
		|=> st.per_cnt == '0 && !period_channel_output_a)
		else $error("period channel not restarted low");

	// Synchronous start and register bus
	start_all_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		start_pulse[BIT_CH0] && start_pulse[BIT_PER] |=>
		cnt0 == '0 && st.per_cnt == '0 && st.run[BIT_CH0])
		else $error("synchronous start mismatch");
	start_run_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		start_pulse != '0
		|=> (st.run & $past(start_pulse)) == $past(start_pulse))
		else $error("started channel not running");
	start_take_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		start_pulse != '0 |-> write && !waitrequest)
		else $error("start outside an accepted write");
	stop_take_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		wr_take && address == OFF_STOP && byteenable[0]
		|=> (st.run & $past(writedata[CH_NUM-1:0])) == '0)
		else $error("stopped channel still running");
	answer_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		(read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer late");
	answer_once_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		!waitrequest |=> waitrequest)
		else $error("bus answer held too long");
	idle_wait_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		!read && !write |=> waitrequest)
		else $error("bus answered without request");
	read_idle_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		waitrequest |-> readdata == '0)
		else $error("read data outside an answer");

	// Lockstep, synchronous clear and compare match
	lockstep_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		&st.run && $past(start_pulse) == '0 && $past(&st.run)
		&& $past(start_pulse, 2) == '1
		|-> cnt0 == st.per_cnt && cnt1 == st.per_cnt
		&& cnt2 == st.per_cnt && cnt9 == st.per_cnt)
		else $error("channels drifted after common start");
	start_zero_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		start_pulse[BIT_CH0] |=> pwm_out[3:0] == '0 && cnt0 == '0)
		else $error("channel zero not low at start");
	start_two_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		start_pulse[BIT_CH2] |=> pwm_out[7:6] == '0 && cnt2 == '0)
		else $error("channel two not low at start");
	start_nine_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		start_pulse[BIT_CH9] |=> pwm_out[11:8] == '0 && cnt9 == '0)
		else $error("channel nine not low at start");
	wrap_zero_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		sync_clear && st.run[BIT_CH0] && !start_pulse[BIT_CH0]
		|=> cnt0 == '0 && pwm_out[3:0] == '0)
		else $error("channel zero not cleared with period");
	wrap_one_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		sync_clear && st.run[BIT_CH1] && !start_pulse[BIT_CH1]
		|=> cnt1 == '0)
		else $error("channel one not cleared with period");
	wrap_two_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		sync_clear && st.run[BIT_CH2] && !start_pulse[BIT_CH2]
		|=> cnt2 == '0 && pwm_out[7:6] == '0)
		else $error("channel two not cleared with period");
	wrap_nine_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		sync_clear && st.run[BIT_CH9] && !start_pulse[BIT_CH9]
		|=> cnt9 == '0 && pwm_out[11:8] == '0)
		else $error("channel nine not cleared with period");
	fall_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		sync_clear && st.run[BIT_CH1] && !start_pulse[BIT_CH1]
		|=> pwm_out[5:4] == '0)
		else $error("pwm not low after sync clear");
	rise_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		st.run[BIT_CH2] && tick && !sync_clear && !start_pulse[BIT_CH2]
		&& cnt2 == st.duty[6*CNT_W +: CNT_W] |=> pwm_out[6])
		else $error("pwm did not rise on duty match");
	rise_zero_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		st.run[BIT_CH0] && tick && !sync_clear && !start_pulse[BIT_CH0]
		&& cnt0 == st.duty[3*CNT_W +: CNT_W] |=> pwm_out[3])
		else $error("channel zero output did not rise");
	rise_one_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		st.run[BIT_CH1] && tick && !sync_clear && !start_pulse[BIT_CH1]
		&& cnt1 == st.duty[5*CNT_W +: CNT_W] |=> pwm_out[5])
		else $error("channel one output did not rise");
	rise_nine_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		st.run[BIT_CH9] && tick && !sync_clear && !start_pulse[BIT_CH9]
		&& cnt9 == st.duty[11*CNT_W +: CNT_W] |=> pwm_out[11])
		else $error("channel nine output did not rise");
	pin_idle_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		!tick && start_pulse == '0 |=> $stable(pwm_out))
		else $error("pwm output moved between ticks");
	cnt_idle_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		!tick && start_pulse == '0
		|=> $stable(cnt0) && $stable(cnt1)
		&& $stable(cnt2) && $stable(cnt9))
		else $error("channel counter moved between ticks");
endmodule // synced_twelve_phase_pwm
`default_nettype wire

// [src/pwm_sync_pkg.sv]
`default_nettype none
package pwm_sync_pkg;
	localparam int CNT_W = 16;
	localparam int PHASES = 12;
	localparam int CH_NUM = 5;
	localparam int PRESCALE = 4;
	localparam int PRE_W = 2;
	// Register byte offsets
	localparam logic [7:0] OFF_SYNC_START = 8'h00;
	localparam logic [7:0] OFF_STOP = 8'h04;
	localparam logic [7:0] OFF_PERIOD_A = 8'h08;
	localparam logic [7:0] OFF_DUTY_BASE = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h40;
	localparam logic [7:0] OFF_PERIOD_CNT = 8'h44;
	// Field positions of sync_start_register
	localparam int BIT_CH0 = 0;
	localparam int BIT_CH1 = 1;
	localparam int BIT_CH2 = 2;
	localparam int BIT_PER = 3;
	localparam int BIT_CH9 = 4;
	// Reset values
	localparam logic [CNT_W-1:0] RST_PERIOD = 16'h9C3F;
	localparam logic [CNT_W-1:0] RST_DUTY = 16'hFFFF;
	localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
	// Carrier timing: 1 ms at 40 MHz count clock
	localparam int COUNT_CLK_KHZ = 40_000;
	localparam int CARRIER_US = 1000;
	localparam int CARRIER_TICKS = COUNT_CLK_KHZ * CARRIER_US / 1000;
	localparam int WAIT_CYCLES = 1;
endpackage : pwm_sync_pkg
`default_nettype wire

// [src/pwm_channel.sv]
`default_nettype none
module pwm_channel #(
	parameter int CNT_W = 16,
	parameter int OUTS = 4
) (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Control
	input  wire logic                  tick,
	input  wire logic                  run,
	input  wire logic                  start,
	input  wire logic                  sync_clear,
	input  wire logic [OUTS*CNT_W-1:0] duty,
	// Outputs
	output logic      [CNT_W-1:0]      channel_counter,
	output logic      [OUTS-1:0]       pwm_out
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [OUTS-1:0]  pins;
	} chan_state_t;
	chan_state_t st;
	chan_state_t next_st;

	always_comb begin
		next_st = st;
		if (start) begin
			next_st.cnt = '0;
			next_st.pins = '0;
		end else if (run && tick) begin
			for (int i = 0; i < OUTS; i++) begin
				if (st.cnt == duty[i*CNT_W +: CNT_W]) begin
					next_st.pins[i] = 1'b1;
				end
			end
			if (sync_clear) begin
				next_st.cnt = '0;
				next_st.pins = '0;
			end else begin
				next_st.cnt = st.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign channel_counter = st.cnt;
	assign pwm_out = st.pins;

	clear_zero_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		run && tick && sync_clear && !start |=> st.cnt == '0)
		else $error("counter not cleared on sync clear");
	start_low_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		start |=> pwm_out == '0)
		else $error("outputs not low at start");
	count_step_a: assert property (@(posedge clk)
		disable iff (!rst_n)
		run && tick && !sync_clear && !start
		|=> st.cnt == $past(st.cnt) + 1'b1)
		else $error("counter did not step by one");
endmodule // pwm_channel
`default_nettype wire

// [testbench/power_stage_model.sv]
`default_nettype none
module power_stage_model
	import pwm_sync_pkg::*;
(
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// Gate inputs from the pins
	input  wire logic [pwm_sync_pkg::PHASES-1:0] gate,
	input  wire logic                        carrier,
	// Measurements per carrier half
	output logic      [15:0]                 per,
	output logic      [15:0]                 hi [PHASES],
	output logic      [7:0]                  periods
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        last;
	logic [15:0] c;
	logic [15:0] h [PHASES];
	// Window runs between two carrier toggles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last <= 1'b0;
			c <= 16'h0001;
			per <= 16'h0000;
			periods <= 8'h00;
			for (int i = 0; i < PHASES; i++) begin
				h[i] <= 16'h0000;
				hi[i] <= 16'h0000;
			end
		end else begin
			last <= carrier;
			if (carrier != last) begin
				per <= c;
				c <= 16'h0001;
				periods <= periods + 8'h01;
			end else begin
				c <= c + 16'h0001;
			end
			for (int i = 0; i < PHASES; i++) begin
				if (carrier != last) begin
					hi[i] <= h[i] + 16'(gate[i]);
					h[i] <= 16'h0000;
				end else begin
					h[i] <= h[i] + 16'(gate[i]);
				end
			end
		end
	end
endmodule // power_stage_model
`default_nettype wire

// [testbench/tb.sv]
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module tb;
	import pwm_sync_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int A = 19;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  address = 8'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0000_0000;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [PHASES-1:0] pwm_out;
	logic        carrier;
	logic [15:0] per;
	logic [15:0] hi [PHASES];
	logic [7:0]  periods;
	logic [31:0] rd;
	int          fail_count = 0;
	int          compares = 0;
	int          cyc = 0;
	always #50 clk = ~clk;
	synced_twelve_phase_pwm u_dut (
		.clk(clk), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(4'hF),
		.readdata(readdata), .waitrequest(waitrequest),
		.pwm_out(pwm_out), .period_channel_output_a(carrier));
	power_stage_model u_load (
		.clk(clk), .rst_n(rst_n), .gate(pwm_out), .carrier(carrier),
		.per(per), .hi(hi), .periods(periods));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// One Avalon transfer; held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= w;
		read <= ~w;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			fail_count++;
			end_sim();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		`CHK(pwm_out, 12'h000)
		`CHK(carrier, 1'b0)
		`CHK(waitrequest, 1'b1)
		`CHK(readdata, 32'h0000_0000)
		bus(0, OFF_PERIOD_A, 32'h0); `CHK(rd, 32'h0000_9C3F)
		bus(0, OFF_DUTY_BASE, 32'h0); `CHK(rd, 32'h0000_FFFF)
		bus(0, OFF_STATUS, 32'h0); `CHK(rd, 32'h0000_0000)
		bus(0, 8'h80, 32'h0); `CHK(rd, 32'h0000_0000)
		bus(1, OFF_PERIOD_A, 32'(A));
		for (int i = 0; i < PHASES; i++) begin
			bus(1, OFF_DUTY_BASE + 8'(4 * i), 32'(i + 1));
			bus(0, OFF_DUTY_BASE + 8'(4 * i), 32'h0);
			`CHK(rd, 32'(i + 1))
		end
		bus(1, OFF_SYNC_START, 32'h0000_001F);
		bus(0, OFF_STATUS, 32'h0); `CHK(rd, 32'h0000_001F)
		`CHK(pwm_out[11:4], 8'h00)
		for (int n = 0; n < 3000 && periods < 8'd4; n++) @(posedge clk);
		// Carrier half: A+1 ticks of four clocks each
		`CHK(per, 16'((A + 1) * PRESCALE))
		for (int i = 0; i < PHASES; i++) begin
			`CHK(hi[i], 16'((A - i - 1) * PRESCALE))
		end
		bus(1, OFF_STOP, 32'h0000_001F);
		bus(0, OFF_STATUS, 32'h0); `CHK(rd, 32'h0000_0000)
		bus(1, OFF_SYNC_START, 32'h0000_001F);
		bus(0, OFF_STATUS, 32'h0); `CHK(rd, 32'h0000_001F)
		`CHK(pwm_out[11:4], 8'h00)
		end_sim();
	end
endmodule // tb
`default_nettype wire
